// ==== rtl/sfs_supervisor.sv ====
/*
 * Steering fault supervisor: latches fault detections, picks the worst
 * steer action and traction action, runs the grace timer and drives the
 * steering command bundle, traction code and flash code.
 * Assumes fault detections come from logic on sys_clk; the key switch and
 * the traction stopped signal are pins and are synchronised here.
 */
`include "sfs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sfs_supervisor #(
    parameter int TICK_CYCLES = `SFS_CLK_MHZ * `SFS_TICK_US
) (
    input wire logic sys_clk, // System clock, 250 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [`SFS_NFAULT-1:0] fault_detect, // Fault conditions.
    input wire logic key_switch_input, // Key switch pin, high when on.
    input wire logic traction_stopped, // Traction motor stopped, pin.
    input wire logic [`SFS_GRACE_W-1:0] grace_timeout_ms, // Grace time.
    output sfs_pkg::sfs_steer_s steer_q, // Steering command bundle.
    output logic [1:0] traction_code_q, // Traction action code.
    output logic [`SFS_CODE_W-1:0] flash_code_q, // Lowest active code.
    output logic [`SFS_NFAULT-1:0] fault_q // Latched fault flags.
);

    localparam int TICK_W = $clog2(TICK_CYCLES);

    // ============================================================
    // Fault table
    // One row per fault input bit; the bit order follows the flash codes.
    function automatic sfs_pkg::sfs_row_s sfs_row(input int idx);
        sfs_pkg::sfs_row_s r;
        r = '{`SFS_CODE_NONE, sfs_pkg::SFS_ACT_NONE, `SFS_TRAC_NONE, 1'b1};
        case (idx)
            0: r = '{`SFS_CODE_OVERCUR, sfs_pkg::SFS_ACT_SHUT,
                     `SFS_TRAC_STOP, 1'b1};
            1: r = '{`SFS_CODE_ISENSE, sfs_pkg::SFS_ACT_SHUT,
                     `SFS_TRAC_STOP, 1'b1};
            2: r = '{`SFS_CODE_PRECHG, sfs_pkg::SFS_ACT_SHUT,
                     `SFS_TRAC_STOP, 1'b1};
            3: r = '{`SFS_CODE_UNDTEMP, sfs_pkg::SFS_ACT_WARN,
                     `SFS_TRAC_NONE, 1'b0};
            4: r = '{`SFS_CODE_OVRTEMP, sfs_pkg::SFS_ACT_WARN_SHUT,
                     `SFS_TRAC_STOP, 1'b1};
            5: r = '{`SFS_CODE_UNDVOLT, sfs_pkg::SFS_ACT_SHUT,
                     `SFS_TRAC_STOP, 1'b1};
            6: r = '{`SFS_CODE_OVRVOLT, sfs_pkg::SFS_ACT_SHUT,
                     `SFS_TRAC_STOP, 1'b1};
            7: r = '{`SFS_CODE_POLARITY, sfs_pkg::SFS_ACT_SHUT,
                     `SFS_TRAC_STOP, 1'b1};
            8: r = '{`SFS_CODE_SUP5V, sfs_pkg::SFS_ACT_HOLD_SHUT,
                     `SFS_TRAC_STOP, 1'b1};
            9: r = '{`SFS_CODE_SUP12V, sfs_pkg::SFS_ACT_WARN_SHUT,
                     `SFS_TRAC_STOP, 1'b1};
            10: r = '{`SFS_CODE_MOTHOT, sfs_pkg::SFS_ACT_REDUCE,
                      `SFS_TRAC_REDUCE, 1'b0};
            11: r = '{`SFS_CODE_MAINDRV, sfs_pkg::SFS_ACT_WARN_SHUT,
                      `SFS_TRAC_STOP, 1'b1};
            12: r = '{`SFS_CODE_MSHORT, sfs_pkg::SFS_ACT_SHUT,
                      `SFS_TRAC_STOP, 1'b1};
            13: r = '{`SFS_CODE_ENCODER, sfs_pkg::SFS_ACT_HOLD_SHUT,
                      `SFS_TRAC_STOP, 1'b1};
            14: r = '{`SFS_CODE_FOUT, sfs_pkg::SFS_ACT_SHUT,
                      `SFS_TRAC_STOP, 1'b1};
            15: r = '{`SFS_CODE_STALL, sfs_pkg::SFS_ACT_SHUT,
                      `SFS_TRAC_STOP, 1'b1};
            default: r = '{`SFS_CODE_NONE, sfs_pkg::SFS_ACT_NONE,
                           `SFS_TRAC_NONE, 1'b1};
        endcase
        return r;
    endfunction : sfs_row

    // Table rows held as an array, so that fields are picked by plain selects.
    sfs_pkg::sfs_row_s row_tab [`SFS_NFAULT];

    always_comb begin
        for (int i = 0; i < `SFS_NFAULT; i++) begin
            row_tab[i] = sfs_row(i);
        end
    end

    // ============================================================
    // Pin synchronisers
    logic key_meta_q;
    logic key_sync_q;
    logic key_prev_q;
    logic stop_meta_q;
    logic stop_sync_q;

    // Two stages on each pin; only the second stage is read by logic.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_meta_q <= 1'b1;
            key_sync_q <= 1'b1;
            stop_meta_q <= 1'b0;
            stop_sync_q <= 1'b0;
        end else begin
            key_meta_q <= key_switch_input;
            key_sync_q <= key_meta_q;
            stop_meta_q <= traction_stopped;
            stop_sync_q <= stop_meta_q;
        end
    end

    // Key history for edge detection; reset as on, so a key already on at
    // power-up neither arms nor completes a cycle.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_prev_q <= 1'b1;
        end else begin
            key_prev_q <= key_sync_q;
        end
    end

    // ============================================================
    // Key cycle detection
    // The key must be seen off before its return clears a fault; any off time arms it,
    // so a fault raised while the key is already off clears when the key returns.
    logic key_off_seen_q;
    logic key_cycle;

    assign key_cycle = key_sync_q && !key_prev_q && key_off_seen_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_off_seen_q <= 1'b0;
        end else if (!key_sync_q) begin
            key_off_seen_q <= 1'b1;
        end else if (key_cycle) begin
            key_off_seen_q <= 1'b0;
        end
    end

    // ============================================================
    // Fault latches
    logic [`SFS_NFAULT-1:0] fault_d;

    // Key-cycle faults hold until the key returns; a detection in the same
    // cycle as the clear wins. Self-clearing faults follow the condition.
    always_comb begin
        for (int i = 0; i < `SFS_NFAULT; i++) begin
            if (row_tab[i].key_clear) begin
                fault_d[i] = fault_detect[i] ||
                             (fault_q[i] && !key_cycle);
            end else begin
                fault_d[i] = fault_detect[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_q <= '0;
        end else begin
            fault_q <= fault_d;
        end
    end

    // ============================================================
    // Worst action, traction code and flash code
    // Computed from the next latch value so that a shutdown fault reaches
    // the drive outputs on the same edge that latches it.
    sfs_pkg::sfs_action_e worst_d;
    logic [1:0] trac_d;
    logic [`SFS_CODE_W-1:0] code_d;
    logic reduce_d;

    always_comb begin
        worst_d = sfs_pkg::SFS_ACT_NONE;
        trac_d = `SFS_TRAC_NONE;
        code_d = `SFS_CODE_NONE;
        reduce_d = 1'b0;
        for (int i = `SFS_NFAULT - 1; i >= 0; i--) begin
            if (fault_d[i]) begin
                if (row_tab[i].action > worst_d) begin
                    worst_d = row_tab[i].action;
                end
                if (row_tab[i].traction < trac_d) begin
                    trac_d = row_tab[i].traction;
                end
                if (row_tab[i].action == sfs_pkg::SFS_ACT_REDUCE) begin
                    reduce_d = 1'b1;
                end
                code_d = row_tab[i].code;
            end
        end
    end

    // ============================================================
    // Millisecond tick for the grace timer
    logic [TICK_W-1:0] tick_cnt_q;
    logic tick_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // ============================================================
    // Supervisor state machine
    sfs_pkg::sfs_state_e state_q;
    sfs_pkg::sfs_state_e state_d;
    logic [`SFS_GRACE_W-1:0] grace_cnt_q;
    logic grace_done;

    // The tick is free running, so the grace time is good to one tick.
    assign grace_done = (grace_cnt_q >= grace_timeout_ms);

    always_comb begin
        state_d = state_q;
        case (state_q)
            sfs_pkg::SFS_ST_RUN: begin
                if (worst_d == sfs_pkg::SFS_ACT_SHUT) begin
                    state_d = sfs_pkg::SFS_ST_SHUT;
                end else if (worst_d >= sfs_pkg::SFS_ACT_WARN_SHUT) begin
                    state_d = sfs_pkg::SFS_ST_GRACE;
                end
            end
            sfs_pkg::SFS_ST_GRACE: begin
                if (worst_d == sfs_pkg::SFS_ACT_SHUT ||
                    stop_sync_q || grace_done) begin
                    state_d = sfs_pkg::SFS_ST_SHUT;
                end else if (worst_d < sfs_pkg::SFS_ACT_WARN_SHUT) begin
                    state_d = sfs_pkg::SFS_ST_RUN;
                end
            end
            sfs_pkg::SFS_ST_SHUT: begin
                if (worst_d < sfs_pkg::SFS_ACT_WARN_SHUT) begin
                    state_d = sfs_pkg::SFS_ST_RUN;
                end
            end
            default: state_d = sfs_pkg::SFS_ST_SHUT;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= sfs_pkg::SFS_ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Grace counter runs only in the grace state and restarts on entry.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            grace_cnt_q <= '0;
        end else if (state_q != sfs_pkg::SFS_ST_GRACE) begin
            grace_cnt_q <= '0;
        end else if (tick_q && !grace_done) begin
            grace_cnt_q <= grace_cnt_q + 1'b1;
        end
    end

    // ============================================================
    // Registered outputs
    // Drive and fault output fall together on shutdown; hold applies only
    // while a hold-class fault is the worst one during the grace period.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            steer_q <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        end else begin
            steer_q.drive_en <= (state_d != sfs_pkg::SFS_ST_SHUT);
            steer_q.fault_out <= (state_d != sfs_pkg::SFS_ST_SHUT);
            steer_q.hold <= (state_d == sfs_pkg::SFS_ST_GRACE) &&
                (worst_d == sfs_pkg::SFS_ACT_HOLD_SHUT);
            steer_q.reduce <= reduce_d;
            steer_q.warning <= (fault_d != '0);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            traction_code_q <= `SFS_TRAC_NONE;
            flash_code_q <= `SFS_CODE_NONE;
        end else begin
            traction_code_q <= trac_d;
            flash_code_q <= code_d;
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_warn_only;
        (fault_q == (`SFS_NFAULT'(1) << 3)) |->
            steer_q.drive_en && !steer_q.hold && steer_q.warning &&
            !steer_q.reduce && traction_code_q == `SFS_TRAC_NONE;
    endproperty
    a_warn_only: assert property (p_warn_only)
        else $error("Warning-only fault changed steering.");

    property p_shut_now;
        fault_detect[0] |=> !steer_q.drive_en && !steer_q.fault_out;
    endproperty
    a_shut_now: assert property (p_shut_now)
        else $error("Shutdown fault did not stop drive at once.");

    property p_reduce;
        fault_q[10] && state_q != sfs_pkg::SFS_ST_SHUT |->
            steer_q.reduce && steer_q.drive_en && steer_q.warning;
    endproperty
    a_reduce: assert property (p_reduce)
        else $error("Hot cutback did not reduce current.");

    property p_grace_stop;
        state_q == sfs_pkg::SFS_ST_GRACE && stop_sync_q |=>
            state_q == sfs_pkg::SFS_ST_SHUT && !steer_q.drive_en;
    endproperty
    a_grace_stop: assert property (p_grace_stop)
        else $error("Traction stop did not end the grace period.");

    property p_hold;
        state_q == sfs_pkg::SFS_ST_GRACE && fault_q[13] && !fault_q[0] |->
            steer_q.hold && steer_q.drive_en;
    endproperty
    a_hold: assert property (p_hold)
        else $error("Encoder fault did not hold wheel position.");

    property p_trac_stop;
        fault_q[0] |-> traction_code_q == `SFS_TRAC_STOP;
    endproperty
    a_trac_stop: assert property (p_trac_stop)
        else $error("Overcurrent did not request traction stop.");

    property p_idle_code;
        fault_q == '0 |-> traction_code_q == `SFS_TRAC_NONE &&
            flash_code_q == `SFS_CODE_NONE && steer_q.fault_out;
    endproperty
    a_idle_code: assert property (p_idle_code)
        else $error("Codes wrong with no fault active.");

    property p_latch;
        fault_q[4] && key_sync_q && key_prev_q |=> fault_q[4];
    endproperty
    a_latch: assert property (p_latch)
        else $error("Key-cycle fault cleared without key cycle.");

    property p_auto_clear;
        !fault_detect[3] |=> !fault_q[3];
    endproperty
    a_auto_clear: assert property (p_auto_clear)
        else $error("Undertemperature fault did not clear by itself.");

    property p_timer;
        state_q == sfs_pkg::SFS_ST_GRACE && grace_done |=>
            state_q == sfs_pkg::SFS_ST_SHUT;
    endproperty
    a_timer: assert property (p_timer)
        else $error("Grace timer expiry did not shut down.");

    c_grace: cover property (state_q == sfs_pkg::SFS_ST_RUN ##1
        state_q == sfs_pkg::SFS_ST_GRACE);
    c_stop_shut: cover property (state_q == sfs_pkg::SFS_ST_GRACE &&
        stop_sync_q ##1 state_q == sfs_pkg::SFS_ST_SHUT);
    c_timer_shut: cover property (state_q == sfs_pkg::SFS_ST_GRACE &&
        grace_done && !stop_sync_q);
    c_key_clear: cover property (key_cycle && fault_q != '0);

endmodule : sfs_supervisor

`default_nettype wire

// ==== shared/sfs_cfg.svh ====
/*
 * Constants of the steering fault supervisor: flash codes, traction codes,
 * fault vector layout and timing figures.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH

// ============================================================
// Fault vector layout
`define SFS_NFAULT 16
`define SFS_CODE_W 6

// ============================================================
// Flash codes shown by the programmer, one per fault input bit
`define SFS_CODE_NONE     6'h00
`define SFS_CODE_OVERCUR  6'h0C
`define SFS_CODE_ISENSE   6'h0D
`define SFS_CODE_PRECHG   6'h0E
`define SFS_CODE_UNDTEMP  6'h0F
`define SFS_CODE_OVRTEMP  6'h10
`define SFS_CODE_UNDVOLT  6'h11
`define SFS_CODE_OVRVOLT  6'h12
`define SFS_CODE_POLARITY 6'h17
`define SFS_CODE_SUP5V    6'h18
`define SFS_CODE_SUP12V   6'h19
`define SFS_CODE_MOTHOT   6'h1A
`define SFS_CODE_MAINDRV  6'h1F
`define SFS_CODE_MSHORT   6'h21
`define SFS_CODE_ENCODER  6'h22
`define SFS_CODE_FOUT     6'h23
`define SFS_CODE_STALL    6'h24

// ============================================================
// Traction action codes sent to the traction controller
`define SFS_TRAC_STOP   2'h1
`define SFS_TRAC_REDUCE 2'h2
`define SFS_TRAC_NONE   2'h3

// ============================================================
// Timing: the grace timer counts in milliseconds
`define SFS_CLK_MHZ     250
`define SFS_TICK_US     1000
`define SFS_GRACE_W     16

`endif

// ==== shared/sfs_pkg.sv ====
/*
 * Types of the steering fault supervisor: steer actions, supervisor states,
 * fault table rows and the steering command bundle.
 * Assumes sfs_cfg.svh is on the include path.
 */
`include "sfs_cfg.svh"

package sfs_pkg;

    // ============================================================
    // Steer actions, ordered by severity so that a compare finds the worst.
    typedef enum logic [2:0] {
        SFS_ACT_NONE      = 3'b000,
        SFS_ACT_WARN      = 3'b001,
        SFS_ACT_REDUCE    = 3'b010,
        SFS_ACT_WARN_SHUT = 3'b011,
        SFS_ACT_HOLD_SHUT = 3'b100,
        SFS_ACT_SHUT      = 3'b101
    } sfs_action_e;

    // Supervisor states.
    typedef enum logic [1:0] {
        SFS_ST_RUN   = 2'b00,
        SFS_ST_GRACE = 2'b01,
        SFS_ST_SHUT  = 2'b10
    } sfs_state_e;

    // One row of the fault table.
    typedef struct packed {
        logic [`SFS_CODE_W-1:0] code;
        sfs_action_e action;
        logic [1:0] traction;
        logic key_clear;
    } sfs_row_s;

    // Commands handed to the steering drive.
    typedef struct packed {
        logic drive_en;
        logic fault_out;
        logic hold;
        logic reduce;
        logic warning;
    } sfs_steer_s;

endpackage : sfs_pkg

// ==== testbench/sfs_trac_model.sv ====
/*
 * Behavioural traction controller facing the fault supervisor.
 * Assumes it shares sys_clk and rst_n with the supervisor.
 */
`include "sfs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sfs_trac_model #(
    parameter int STOP_CYCLES = 3
) (
    input wire logic sys_clk, // System clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic [1:0] traction_code, // Code from the supervisor.
    input wire logic allow_stop, // Bench lets the vehicle come to rest.
    output logic traction_stopped // Traction motor at rest.
);
    // ============================================================
    // Vehicle motion
    int cnt_q;
    logic stopped_q;

    // A stop request takes a few cycles to bring the vehicle to rest;
    // any other code means it keeps rolling, so stopped drops at once.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 0;
            stopped_q <= 1'b0;
        end else if (traction_code == `SFS_TRAC_STOP && allow_stop) begin
            cnt_q <= cnt_q + 1;
            stopped_q <= (cnt_q >= STOP_CYCLES);
        end else begin
            cnt_q <= 0;
            stopped_q <= 1'b0;
        end
    end

    assign traction_stopped = stopped_q;

endmodule : sfs_trac_model

`default_nettype wire

// ==== testbench/tb_steer_fault_supervisor.sv ====
/*
 * Self-checking bench for the steering fault supervisor.
 * Assumes sfs_pkg is compiled first and sfs_cfg.svh is on the path.
 */
`include "sfs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_steer_fault_supervisor;
    // ============================================================
    // Signals
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] fault_detect = 16'h0000;
    logic key_switch_input = 1'b1;
    logic [15:0] grace_ms = 16'hFFFF;
    logic allow_stop = 1'b0;
    logic traction_stopped;
    sfs_pkg::sfs_steer_s steer_q;
    logic [1:0] traction_code_q;
    logic [5:0] flash_code_q;
    logic [15:0] fault_q;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [5:0] codes [16] = '{`SFS_CODE_OVERCUR, `SFS_CODE_ISENSE,
        `SFS_CODE_PRECHG, `SFS_CODE_UNDTEMP, `SFS_CODE_OVRTEMP,
        `SFS_CODE_UNDVOLT, `SFS_CODE_OVRVOLT, `SFS_CODE_POLARITY,
        `SFS_CODE_SUP5V, `SFS_CODE_SUP12V, `SFS_CODE_MOTHOT,
        `SFS_CODE_MAINDRV, `SFS_CODE_MSHORT, `SFS_CODE_ENCODER,
        `SFS_CODE_FOUT, `SFS_CODE_STALL};

    // A short tick keeps the grace timer within a few dozen cycles.
    sfs_supervisor #(.TICK_CYCLES(10)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .fault_detect(fault_detect),
        .key_switch_input(key_switch_input),
        .traction_stopped(traction_stopped), .grace_timeout_ms(grace_ms),
        .steer_q(steer_q), .traction_code_q(traction_code_q),
        .flash_code_q(flash_code_q), .fault_q(fault_q));

    sfs_trac_model partner (
        .sys_clk(sys_clk), .rst_n(rst_n), .traction_code(traction_code_q),
        .allow_stop(allow_stop), .traction_stopped(traction_stopped));

    // ============================================================
    // Clock and hang guard
    always #2 sys_clk = ~sys_clk;

    // A hang costs one mismatch and ends the run.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end

    // ============================================================
    // Helpers
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // Drives the fault vector on an edge; it is sampled one edge later.
    task automatic detect(input logic [15:0] v);
        @(posedge sys_clk);
        fault_detect <= v;
        tick(1);
    endtask : detect

    task automatic key_cycle();
        @(posedge sys_clk);
        key_switch_input <= 1'b0;
        repeat (4) @(posedge sys_clk);
        key_switch_input <= 1'b1;
        tick(5);
    endtask : key_cycle

    function automatic sfs_pkg::sfs_action_e cls(input int i);
        case (i)
            3: return sfs_pkg::SFS_ACT_WARN;
            10: return sfs_pkg::SFS_ACT_REDUCE;
            4, 9, 11: return sfs_pkg::SFS_ACT_WARN_SHUT;
            8, 13: return sfs_pkg::SFS_ACT_HOLD_SHUT;
            default: return sfs_pkg::SFS_ACT_SHUT;
        endcase
    endfunction : cls

    function automatic logic [15:0] exp_steer(input sfs_pkg::sfs_action_e c);
        return {11'h000, c != sfs_pkg::SFS_ACT_SHUT,
            c != sfs_pkg::SFS_ACT_SHUT, c == sfs_pkg::SFS_ACT_HOLD_SHUT,
            c == sfs_pkg::SFS_ACT_REDUCE, 1'b1};
    endfunction : exp_steer

    // ============================================================
    // Scenarios
    // Every fault alone: its actions, then how it clears.
    task automatic t_table();
        sfs_pkg::sfs_action_e c;
        logic [1:0] tr;
        int n;
        for (int i = 0; i < 16; i++) begin
            c = cls(i);
            tr = (i == 3) ? `SFS_TRAC_NONE : (i == 10) ? `SFS_TRAC_REDUCE
                : `SFS_TRAC_STOP;
            detect(16'h0001 << i);
            check(fault_q, 16'h0001 << i);
            check({11'h000, steer_q}, exp_steer(c));
            check({14'h0000, traction_code_q}, {14'h0000, tr});
            check({10'h000, flash_code_q}, {10'h000, codes[i]});
            detect(16'h0000);
            tick(1);
            if (i == 3 || i == 10) begin
                check(fault_q, 16'h0000);
                check({11'h000, steer_q}, 16'h0018);
            end else begin
                check(fault_q, 16'h0001 << i);
                if (c != sfs_pkg::SFS_ACT_SHUT) begin
                    @(posedge sys_clk);
                    allow_stop <= 1'b1;
                    n = 0;
                    while (steer_q.drive_en === 1'b1 && n < 20) begin
                        tick(1);
                        n++;
                    end
                    check({11'h000, steer_q}, 16'h0001);
                    @(posedge sys_clk);
                    allow_stop <= 1'b0;
                end
                key_cycle();
                check(fault_q, 16'h0000);
                check({11'h000, steer_q}, 16'h0018);
            end
        end
    endtask : t_table

    // Grace timer runs out while the vehicle keeps rolling.
    task automatic t_timer();
        int el;
        @(posedge sys_clk);
        grace_ms <= 16'h0003;
        detect(16'h0010);
        tick(15);
        check({15'h0000, steer_q.drive_en}, 16'h0001);
        el = 15;
        while (steer_q.drive_en === 1'b1 && el < 60) begin
            tick(1);
            el++;
        end
        check({15'h0000, el >= 20 && el <= 33}, 16'h0001);
        check({11'h000, steer_q}, 16'h0001);
        detect(16'h0000);
        key_cycle();
        @(posedge sys_clk);
        grace_ms <= 16'hFFFF;
    endtask : t_timer

    // Faults stack: the worst steer and traction action wins.
    task automatic t_combine();
        detect(16'h0400);
        check({14'h0000, traction_code_q}, 16'h0002);
        detect(16'h0410);
        check({14'h0000, traction_code_q}, 16'h0001);
        check({15'h0000, steer_q.drive_en}, 16'h0001);
        detect(16'h0411);
        // The hot cutback flag stays up beside the shutdown.
        check({11'h000, steer_q}, 16'h0003);
        check({10'h000, flash_code_q}, 16'h000C);
        detect(16'h0000);
        tick(2);
        check(fault_q, 16'h0011);
        key_cycle();
        check(fault_q, 16'h0000);
        check({14'h0000, traction_code_q}, 16'h0003);
    endtask : t_combine

    // ============================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(2);
        check({11'h000, steer_q}, 16'h0018);
        t_table();
        t_timer();
        t_combine();
        final_report();
    end

endmodule : tb_steer_fault_supervisor

`default_nettype wire
